// File: rtl/pdpc_ports.sv
/*
 Port data, direction and pull-up registers of the general-purpose ports,
 with address decode on the processor byte bus. Assumes the processor does
 bit operations as byte read, modify, byte write.
*/
`timescale 1ns/1ps
`default_nettype none
module pdpc_ports (
   // Clock and reset
   input  wire logic                           clock,
   input  wire logic                           rst,
   // Processor byte bus
   input  wire logic [15:0]                    addr,
   input  wire logic                           wrEn,
   input  wire logic [7:0]                     wrData,
   input  wire logic                           rdEn,
   output var  logic [7:0]                     rdData,
   // Port 0 pins
   input  wire logic [pdpc_pkg::PORT0_W-1:0]   port0In,
   output var  logic [pdpc_pkg::PORT0_W-1:0]   port0Out,
   output var  logic [pdpc_pkg::PORT0_W-1:0]   port0Oe,
   output var  logic [pdpc_pkg::PORT0_W-1:0]   port0Pullup,
   // Port 1 pins
   input  wire logic [pdpc_pkg::PORT1_W-1:0]   port1In,
   output var  logic [pdpc_pkg::PORT1_W-1:0]   port1Out,
   output var  logic [pdpc_pkg::PORT1_W-1:0]   port1Oe,
   output var  logic [pdpc_pkg::PORT1_W-1:0]   port1Pullup,
   // Port 2 pins, input only
   input  wire logic [pdpc_pkg::PORT2_W-1:0]   port2In,
   // Port 3 pins
   input  wire logic [pdpc_pkg::PORT3_W-1:0]   port3In,
   output var  logic [pdpc_pkg::PORT3_W-1:0]   port3Out,
   output var  logic [pdpc_pkg::PORT3_W-1:0]   port3Oe,
   output var  logic [pdpc_pkg::PORT3_W-1:0]   port3Pullup,
   // Port 12 pin
   input  wire logic [pdpc_pkg::PORT12_W-1:0]  port12In,
   output var  logic [pdpc_pkg::PORT12_W-1:0]  port12Out,
   output var  logic [pdpc_pkg::PORT12_W-1:0]  port12Oe,
   output var  logic [pdpc_pkg::PORT12_W-1:0]  port12Pullup,
   // Port 13 pin, output only
   output var  logic [pdpc_pkg::PORT13_W-1:0]  port13Out
);
   import pdpc_pkg::*;

   pdpc_slice_if s0 ();
   pdpc_slice_if s1 ();
   pdpc_slice_if s2 ();
   pdpc_slice_if s3 ();
   pdpc_slice_if s12 ();

   logic [7:0]          rdData_r;
   logic [PORT13_W-1:0] port13_r;
   wire  [7:0]          rdData_nxt;
   wire  [7:0]          port13Rd;
   wire                 hitPort13;
   wire                 hitData0;
   wire                 hitData1;
   wire                 hitData2;
   wire                 hitData3;
   wire                 hitData12;
   wire                 hitData13;
   wire                 hitDir0;
   wire                 hitDir1;
   wire                 hitDir3;
   wire                 hitDir12;
   wire                 hitPull0;
   wire                 hitPull1;
   wire                 hitPull3;
   wire                 hitPull12;
   wire                 hitNone;

   ////////////////////////////////////////////////////////////////////////
   // Decode: whole byte always, bit ops arrive as byte writes
   assign s0.latchWr  = wrEn && addr == PORT0_ADDR; // RQ10 RQ14
   assign s0.dirWr    = wrEn && addr == DIR0_ADDR;
   assign s0.pullWr   = wrEn && addr == PULL0_ADDR;
   assign s0.wrData   = wrData;
   assign s1.latchWr  = wrEn && addr == PORT1_ADDR;
   assign s1.dirWr    = wrEn && addr == DIR1_ADDR;
   assign s1.pullWr   = wrEn && addr == PULL1_ADDR;
   assign s1.wrData   = wrData;
   // Analog-shared port has no writable state at all
   assign s2.latchWr  = 1'b0; // RQ16
   assign s2.dirWr    = 1'b0;
   assign s2.pullWr   = 1'b0;
   assign s2.wrData   = wrData;
   assign s3.latchWr  = wrEn && addr == PORT3_ADDR;
   assign s3.dirWr    = wrEn && addr == DIR3_ADDR;
   assign s3.pullWr   = wrEn && addr == PULL3_ADDR;
   assign s3.wrData   = wrData;
   assign s12.latchWr = wrEn && addr == PORT12_ADDR;
   assign s12.dirWr   = wrEn && addr == DIR12_ADDR;
   assign s12.pullWr  = wrEn && addr == PULL12_ADDR;
   assign s12.wrData  = wrData;
   assign hitPort13   = wrEn && addr == PORT13_ADDR;

   ////////////////////////////////////////////////////////////////////////
   // Address hits for the read side, one compare per register
   assign hitData0  = addr == PORT0_ADDR;
   assign hitData1  = addr == PORT1_ADDR;
   assign hitData2  = addr == PORT2_ADDR;
   assign hitData3  = addr == PORT3_ADDR;
   assign hitData12 = addr == PORT12_ADDR;
   assign hitData13 = addr == PORT13_ADDR;
   assign hitDir0   = addr == DIR0_ADDR;
   assign hitDir1   = addr == DIR1_ADDR;
   assign hitDir3   = addr == DIR3_ADDR;
   assign hitDir12  = addr == DIR12_ADDR;
   assign hitPull0  = addr == PULL0_ADDR;
   assign hitPull1  = addr == PULL1_ADDR;
   assign hitPull3  = addr == PULL3_ADDR;
   assign hitPull12 = addr == PULL12_ADDR;
   // Outside the map: reads answer zero, writes go nowhere
   assign hitNone   = ~|{hitData0, hitData1, hitData2, hitData3, hitData12, hitData13,
                         hitDir0, hitDir1, hitDir3, hitDir12,
                         hitPull0, hitPull1, hitPull3, hitPull12};

   ////////////////////////////////////////////////////////////////////////
   pdpc_port_slice #(.WIDTH(PORT0_W), .HAS_OUT(1'b1)) u_port0 (
      .clock    (clock),
      .rst      (rst),
      .bus      (s0),
      .pinIn    (port0In),
      .pinOut   (port0Out),
      .pinOe    (port0Oe),
      .pullupEn (port0Pullup)
   );

   pdpc_port_slice #(.WIDTH(PORT1_W), .HAS_OUT(1'b1)) u_port1 (
      .clock    (clock),
      .rst      (rst),
      .bus      (s1),
      .pinIn    (port1In),
      .pinOut   (port1Out),
      .pinOe    (port1Oe),
      .pullupEn (port1Pullup)
   );

   pdpc_port_slice #(.WIDTH(PORT2_W), .HAS_OUT(1'b0)) u_port2 (
      .clock    (clock),
      .rst      (rst),
      .bus      (s2),
      .pinIn    (port2In),
      .pinOut   (),
      .pinOe    (),
      .pullupEn ()
   );

   pdpc_port_slice #(.WIDTH(PORT3_W), .HAS_OUT(1'b1)) u_port3 (
      .clock    (clock),
      .rst      (rst),
      .bus      (s3),
      .pinIn    (port3In),
      .pinOut   (port3Out),
      .pinOe    (port3Oe),
      .pullupEn (port3Pullup)
   );

   pdpc_port_slice #(.WIDTH(PORT12_W), .HAS_OUT(1'b1)) u_port12 (
      .clock    (clock),
      .rst      (rst),
      .bus      (s12),
      .pinIn    (port12In),
      .pinOut   (port12Out),
      .pinOe    (port12Oe),
      .pullupEn (port12Pullup)
   );

   ////////////////////////////////////////////////////////////////////////
   // Output-only port: no direction, reads back its latch
   always_ff @(posedge clock) begin
      if (rst) begin
         port13_r <= LATCH_RST[PORT13_W-1:0]; // RQ17
      end else if (hitPort13) begin
         port13_r <= wrData[PORT13_W-1:0];
      end
   end
   assign port13Out = port13_r;
   assign port13Rd  = {{(8-PORT13_W){1'b0}}, port13_r}; // RQ18

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses answer zero
   assign rdData_nxt =
      hitData0  ? s0.latchRd  :
      hitData1  ? s1.latchRd  :
      hitData2  ? s2.latchRd  :
      hitData3  ? s3.latchRd  :
      hitData12 ? s12.latchRd :
      hitData13 ? port13Rd    :
      hitDir0   ? s0.dirRd    :
      hitDir1   ? s1.dirRd    :
      hitDir3   ? s3.dirRd    :
      hitDir12  ? s12.dirRd   :
      hitPull0  ? s0.pullRd   :
      hitPull1  ? s1.pullRd   :
      hitPull3  ? s3.pullRd   :
      hitPull12 ? s12.pullRd  :
      UNMAPPED_RD; // RQ2 RQ7

   // Registered so the bus sees a flop; answer one cycle after rdEn
   always_ff @(posedge clock) begin
      if (rst) begin
         rdData_r <= UNMAPPED_RD;
      end else if (rdEn) begin
         rdData_r <= rdData_nxt;
      end
   end
   assign rdData = rdData_r;

   ////////////////////////////////////////////////////////////////////////
   port13_reset_a: assert property (@(posedge clock) rst |=> port13Out == '0) // RQ17
      else $error("last port not low after reset");
   port13_write_a: assert property (@(posedge clock) disable iff (rst) // RQ1
      hitPort13 |=> port13Out == $past(wrData[PORT13_W-1:0]))
      else $error("last port missed a write");
   unmapped_read_a: assert property (@(posedge clock) disable iff (rst) // RQ18
      rdEn && addr[15:8] != 8'hff |=> rdData == UNMAPPED_RD)
      else $error("unmapped read not zero");
   upper_zero_a: assert property (@(posedge clock) disable iff (rst) // RQ18
      rdEn && (addr == PORT0_ADDR || addr == PULL3_ADDR) |=> rdData[7:4] == 4'h0)
      else $error("upper bits of narrow port not zero");
   output_read_a: assert property (@(posedge clock) disable iff (rst) // RQ8
      rdEn && addr == PORT1_ADDR |=> ((rdData ^ $past(port1Out)) & $past(port1Oe)) == 8'h00)
      else $error("output port read not latch");
   dir_reset_a: assert property (@(posedge clock) rst ##1 !rst |-> // RQ15
      port0Oe == '0 && port1Oe == '0 && port3Oe == '0 && port12Oe == '0)
      else $error("ports not input after reset");

   ////////////////////////////////////////////////////////////////////////
   // Pin-level view of each port, checked from the outside
   default clocking cb @(posedge clock); endclocking

   port0_load_a: assert property (disable iff (rst) s0.latchWr |=> // RQ1
      port0Out == $past(wrData[PORT0_W-1:0]))
      else $error("port 0 missed a write");
   port1_load_a: assert property (disable iff (rst) s1.latchWr |=> // RQ1
      port1Out == $past(wrData))
      else $error("port 1 missed a write");
   port3_load_a: assert property (disable iff (rst) s3.latchWr |=> // RQ1
      port3Out == $past(wrData[PORT3_W-1:0]))
      else $error("port 3 missed a write");
   port12_load_a: assert property (disable iff (rst) s12.latchWr |=> // RQ1
      port12Out == $past(wrData[PORT12_W-1:0]))
      else $error("port 12 missed a write");
   pull0_gate_a: assert property (disable iff (rst) // RQ11
      (port0Pullup & port0Oe) == '0)
      else $error("port 0 pull-up on while driving");
   pull1_gate_a: assert property (disable iff (rst) // RQ11
      (port1Pullup & port1Oe) == '0)
      else $error("port 1 pull-up on while driving");
   pull3_gate_a: assert property (disable iff (rst) // RQ11
      (port3Pullup & port3Oe) == '0)
      else $error("port 3 pull-up on while driving");
   pull12_gate_a: assert property (disable iff (rst) // RQ11
      (port12Pullup & port12Oe) == '0)
      else $error("port 12 pull-up on while driving");
   dir0_read_a: assert property (disable iff (rst) rdEn && hitDir0 |=> // RQ15
      rdData == ~8'($past(port0Oe)))
      else $error("direction 0 readback wrong");
   dir1_read_a: assert property (disable iff (rst) rdEn && hitDir1 |=> // RQ15
      rdData == ~$past(port1Oe))
      else $error("direction 1 readback wrong");
   dir3_read_a: assert property (disable iff (rst) rdEn && hitDir3 |=> // RQ15
      rdData == ~8'($past(port3Oe)))
      else $error("direction 3 readback wrong");
   dir12_read_a: assert property (disable iff (rst) rdEn && hitDir12 |=> // RQ15
      rdData == ~8'($past(port12Oe)))
      else $error("direction 12 readback wrong");
   pull1_read_a: assert property (disable iff (rst) rdEn && hitPull1 |=> // RQ12
      (rdData & ~$past(port1Oe)) == $past(port1Pullup))
      else $error("pull-up 1 readback wrong");
   pull3_read_a: assert property (disable iff (rst) rdEn && hitPull3 |=> // RQ12 RQ18
      (rdData & ~8'($past(port3Oe))) == 8'($past(port3Pullup)))
      else $error("pull-up 3 readback wrong");
   pin_read_a: assert property (disable iff (rst) rdEn && hitData1 |=> // RQ2 RQ9
      ((rdData ^ $past(port1In, 3)) & ~$past(port1Oe)) == 8'h00)
      else $error("input bit does not read pin");
   read_quiet_a: assert property (disable iff (rst) rdEn && !wrEn |=> // RQ7
      $stable(port0Out) && $stable(port1Out) && $stable(port3Out) && $stable(port12Out))
      else $error("read changed an output latch");
   read_hold_a: assert property (disable iff (rst) !rdEn |=> // RQ2
      $stable(rdData))
      else $error("read data changed without a read");
   port2_read_a: assert property (disable iff (rst) rdEn && hitData2 |=> // RQ16 RQ18
      rdData == 8'($past(port2In, 3)))
      else $error("input-only port read wrong");
   unmapped_any_a: assert property (disable iff (rst) rdEn && hitNone |=> // RQ18
      rdData == UNMAPPED_RD)
      else $error("read outside the map not zero");
   port13_hold_a: assert property (disable iff (rst) !hitPort13 |=> // RQ6
      $stable(port13Out))
      else $error("last port changed without a write");
   dir0_write_a: assert property (disable iff (rst) s0.dirWr |=> // RQ15
      port0Oe == ~$past(wrData[PORT0_W-1:0]))
      else $error("direction 0 write not applied");
   dir1_write_a: assert property (disable iff (rst) s1.dirWr |=> // RQ15
      port1Oe == ~$past(wrData))
      else $error("direction 1 write not applied");
   pull1_write_a: assert property (disable iff (rst) s1.pullWr |=> // RQ11 RQ12
      port1Pullup == ($past(wrData) & ~port1Oe))
      else $error("pull-up 1 write not applied");
   data_oe_keep_a: assert property (disable iff (rst) s1.latchWr |=> // RQ5
      $stable(port1Oe))
      else $error("data write changed port 1 drive");
endmodule
`default_nettype wire

// File: rtl/pdpc_pkg.sv
/*
 Constants of the port data and pull-up block: byte addresses, port widths,
 reset values. Assumes a byte-wide processor data bus with 16-bit addresses.
*/
// Function
// RQ1 - Writing port data loads the latch; output-mode pins drive the latch value.
// RQ2 - Reads return pin level for input bits, latch value for output bits.
// RQ3 - Reset clears all latches; the input-only port reads undefined.
// RQ4 - Data bit 0 means low, 1 means high, driven or sensed.
// RQ5 - Input-mode writes update the latch but leave the pin undriven.
// RQ6 - Latch bits hold until rewritten or reset.
// RQ7 - Reads never alter latch contents.
// RQ8 - Modify on output pins uses latch value, written back and driven.
// RQ9 - Modify on input pins uses pin level; result only reaches latch.
// RQ10 - Bit instructions access the port as a whole byte.
// RQ11 - Pull-up only when selected and pin in input mode.
// RQ12 - Select bit 1 connects the pull-up, 0 leaves it open.
// RQ13 - Reset clears pull-up selects, all pull-ups disconnected.
// RQ14 - Data and pull-up registers accept bit and byte accesses.
// RQ15 - Direction bit 0 output, 1 input; reset sets all to one.
// RQ16 - Four-bit analog-shared port is input only.
// RQ17 - One-bit last port is output only and low during reset.
// RQ18 - Unimplemented upper bits read zero and ignore writes; the direction registers read their unimplemented upper bits as one.
package pdpc_pkg;
   localparam logic [15:0] PORT0_ADDR   = 16'hff00;
   localparam logic [15:0] PORT1_ADDR   = 16'hff01;
   localparam logic [15:0] PORT2_ADDR   = 16'hff02;
   localparam logic [15:0] PORT3_ADDR   = 16'hff03;
   localparam logic [15:0] PORT12_ADDR  = 16'hff0c;
   localparam logic [15:0] PORT13_ADDR  = 16'hff0d;
   localparam logic [15:0] DIR0_ADDR    = 16'hff20;
   localparam logic [15:0] DIR1_ADDR    = 16'hff21;
   localparam logic [15:0] DIR3_ADDR    = 16'hff23;
   localparam logic [15:0] DIR12_ADDR   = 16'hff2c;
   localparam logic [15:0] PULL0_ADDR   = 16'hff30;
   localparam logic [15:0] PULL1_ADDR   = 16'hff31;
   localparam logic [15:0] PULL3_ADDR   = 16'hff33;
   localparam logic [15:0] PULL12_ADDR  = 16'hff3c;
   localparam int          PORT0_W      = 4;
   localparam int          PORT1_W      = 8;
   localparam int          PORT2_W      = 4;
   localparam int          PORT3_W      = 4;
   localparam int          PORT12_W     = 1;
   localparam int          PORT13_W     = 1;
   localparam logic [7:0]  LATCH_RST    = 8'h00;
   localparam logic [7:0]  DIR_RST      = 8'hff;
   localparam logic [7:0]  PULL_RST     = 8'h00;
   localparam logic [7:0]  UNMAPPED_RD  = 8'h00;
endpackage

// File: rtl/pdpc_slice_if.sv
/*
 Register strobes and readback views between the decoder and one port slice.
 Assumes the decoder issues at most one strobe per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
interface pdpc_slice_if;
   logic       latchWr;
   logic       dirWr;
   logic       pullWr;
   logic [7:0] wrData;
   logic [7:0] latchRd;
   logic [7:0] dirRd;
   logic [7:0] pullRd;
   modport ctrl  (output latchWr, dirWr, pullWr, wrData, input latchRd, dirRd, pullRd);
   modport slice (input latchWr, dirWr, pullWr, wrData, output latchRd, dirRd, pullRd);
endinterface
`default_nettype wire

// File: rtl/pdpc_port_slice.sv
/*
 One port: output latch, direction, pull-up select, pin synchroniser and
 readback. Assumes strobes come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pdpc_port_slice #(
   parameter int WIDTH   = 8,
   parameter bit HAS_OUT = 1'b1
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // Register side
   pdpc_slice_if.slice           bus,
   // Pins
   input  wire logic [WIDTH-1:0] pinIn,
   output var  logic [WIDTH-1:0] pinOut,
   output var  logic [WIDTH-1:0] pinOe,
   output var  logic [WIDTH-1:0] pullupEn
);
   import pdpc_pkg::*;

   generate
      if (WIDTH < 1 || WIDTH > 8) begin : g_badWidth
         $error("port slice width must be 1 to 8");
      end
   endgenerate

   logic [WIDTH-1:0] latch_r;
   logic [WIDTH-1:0] oe_r;
   logic [WIDTH-1:0] pull_r;
   logic [WIDTH-1:0] pullEn_r;
   logic [WIDTH-1:0] syncA_r;
   logic [WIDTH-1:0] syncB_r;
   wire  [WIDTH-1:0] oe_nxt;
   wire  [WIDTH-1:0] pull_nxt;
   wire  [WIDTH-1:0] readback;

   ////////////////////////////////////////////////////////////////////////
   // Direction reg stored as drive enable: 0 in the register means drive
   assign oe_nxt   = (HAS_OUT && bus.dirWr) ? ~bus.wrData[WIDTH-1:0] : oe_r; // RQ15 RQ16
   assign pull_nxt = (HAS_OUT && bus.pullWr) ? bus.wrData[WIDTH-1:0] : pull_r; // RQ14
   // Input bits read the pin, so a modify on them captures the level
   assign readback = (oe_r & latch_r) | (~oe_r & syncB_r); // RQ2 RQ8 RQ9 RQ10

   always_ff @(posedge clock) begin
      if (rst) begin
         latch_r  <= LATCH_RST[WIDTH-1:0]; // RQ3
         oe_r     <= ~DIR_RST[WIDTH-1:0]; // RQ15
         pull_r   <= PULL_RST[WIDTH-1:0]; // RQ13
         pullEn_r <= PULL_RST[WIDTH-1:0];
      end else begin
         if (HAS_OUT && bus.latchWr) begin
            latch_r <= bus.wrData[WIDTH-1:0]; // RQ1 RQ5 RQ6
         end
         oe_r     <= oe_nxt;
         pull_r   <= pull_nxt;
         pullEn_r <= pull_nxt & ~oe_nxt; // RQ11 RQ12
      end
   end

   // No reset: pin level is unknown until sampled anyway
   always_ff @(posedge clock) begin
      syncA_r <= pinIn;
      syncB_r <= syncA_r;
   end

   assign pinOut   = latch_r; // RQ4
   assign pinOe    = oe_r;
   assign pullupEn = pullEn_r;

   always_comb begin
      bus.latchRd = 8'h00; // RQ18
      bus.pullRd  = 8'h00;
      bus.dirRd   = 8'hff;
      bus.latchRd[WIDTH-1:0] = readback;
      bus.pullRd[WIDTH-1:0]  = pull_r;
      bus.dirRd[WIDTH-1:0]   = ~oe_r;
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   latch_hold_a: assert property (!bus.latchWr |=> $stable(latch_r)) // RQ6
      else $error("latch changed without a write");
   latch_load_a: assert property (HAS_OUT && bus.latchWr |=> // RQ1
      latch_r == $past(bus.wrData[WIDTH-1:0]))
      else $error("latch did not take written byte");
   input_write_a: assert property (bus.latchWr && !bus.dirWr |=> $stable(oe_r)) // RQ5
      else $error("data write changed drive enable");
   pull_gate_a: assert property ((pullupEn & pinOe) == '0) // RQ11
      else $error("pull-up on while driving");
   pull_select_a: assert property (##1 pullupEn == (pull_r & ~oe_r)) // RQ12
      else $error("pull-up does not follow select");
   input_read_a: assert property (oe_r == '0 && $stable(oe_r) && !$past(rst, 2) |-> // RQ2
      bus.latchRd[WIDTH-1:0] == $past(pinIn, 2))
      else $error("input bit does not read pin");
   reset_clear_a: assert property (disable iff (1'b0) rst |=> // RQ3
      latch_r == '0 && pull_r == '0 && oe_r == '0)
      else $error("reset values wrong");
endmodule
`default_nettype wire

// File: tb/pdpc_pin_model.sv
/*
 Board side of one port: resolves each pin from the device driver, an
 external driver and the internal pull-up. Assumes one clock for the toggle.
*/
`timescale 1ns/1ps
`default_nettype none
module pdpc_pin_model #(
   parameter int W = 8
) (
   // Clock
   input  wire logic         clock,
   // Device side
   input  wire logic [W-1:0] drvOut,
   input  wire logic [W-1:0] drvOe,
   input  wire logic [W-1:0] pullEn,
   // Board drivers
   input  wire logic [W-1:0] extEn,
   input  wire logic [W-1:0] extVal,
   // Resolved level
   output var  logic [W-1:0] level
);
   logic flip_r = 1'b0;
   // Floating pins wander, so a stale level never passes for a read
   always @(posedge clock) begin
      flip_r <= ~flip_r;
   end
   always_comb begin
      level = (drvOe & drvOut)
            | (~drvOe & extEn & extVal)
            | (~drvOe & ~extEn & (pullEn | {W{flip_r}}));
   end
endmodule
`default_nettype wire

// File: tb/port_data_pullup_control_bench.sv
/*
 Self-checking bench of the port block. Assumes byte bus reads return one
 cycle after the strobe edge and pin inputs settle within four cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module port_data_pullup_control_bench;
   import pdpc_pkg::*;
   typedef struct { logic [15:0] a; logic [7:0] d; logic [7:0] e; } pdpc_row_s;
   logic clock = 1'b0, rst = 1'b1, wrEn = 1'b0, rdEn = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wrData = 8'h00, rdData, p1In, p1Out, p1Oe, p1Pu, r;
   logic [7:0]  extEn = 8'h00, extVal = 8'h00;
   logic [3:0]  p0In = 4'h0, p0Out, p0Oe, p0Pu, p2In = 4'ha, p3In = 4'h0, p3Out, p3Oe, p3Pu;
   logic [0:0]  p12In = 1'b0, p12Out, p12Oe, p12Pu, p13Out;
   int error_cnt = 0, tests_run = 0, cycles = 0;
   pdpc_row_s rows [10] = '{'{PULL0_ADDR, 8'hff, 8'h0f}, '{PULL1_ADDR, 8'h3c, 8'h3c},
      '{PULL3_ADDR, 8'hff, 8'h0f}, '{PULL12_ADDR, 8'hff, 8'h01}, '{DIR0_ADDR, 8'h00, 8'hf0},
      '{DIR1_ADDR, 8'h5a, 8'h5a}, '{DIR3_ADDR, 8'h00, 8'hf0}, '{DIR12_ADDR, 8'h00, 8'hfe},
      '{16'hff10, 8'hff, 8'h00}, '{16'h0030, 8'hff, 8'h00}};
   always #2 clock = ~clock;
   pdpc_ports uut (.clock(clock), .rst(rst), .addr(addr), .wrEn(wrEn), .wrData(wrData),
      .rdEn(rdEn), .rdData(rdData), .port0In(p0In), .port0Out(p0Out), .port0Oe(p0Oe),
      .port0Pullup(p0Pu), .port1In(p1In), .port1Out(p1Out), .port1Oe(p1Oe),
      .port1Pullup(p1Pu), .port2In(p2In), .port3In(p3In), .port3Out(p3Out),
      .port3Oe(p3Oe), .port3Pullup(p3Pu), .port12In(p12In), .port12Out(p12Out),
      .port12Oe(p12Oe), .port12Pullup(p12Pu), .port13Out(p13Out));
   pdpc_pin_model #(.W(8)) board1 (.clock(clock), .drvOut(p1Out), .drvOe(p1Oe),
      .pullEn(p1Pu), .extEn(extEn), .extVal(extVal), .level(p1In));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock) #1;
      addr = a;
      wrData = d;
      wrEn = 1'b1;
      @(posedge clock) #1;
      wrEn = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clock) #1;
      addr = a;
      rdEn = 1'b1;
      @(posedge clock) #1;
      rdEn = 1'b0;
      d = rdData;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(v, e);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Hang guard, generous against the hundred or so cycles used
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      repeat (10) @(posedge clock);
      #1 rst = 1'b0;
      chk(8'(p13Out), 8'h00);
      chk(p1Oe, 8'h00);
      chk(p1Pu, 8'h00);
      rd_chk(DIR1_ADDR, 8'hff);
      rd_chk(PULL1_ADDR, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      chk(8'(p0Out), 8'h00);
      chk(8'(p0Pu), 8'h00);
      chk(8'(p3Pu), 8'h00);
      chk(8'(p0Oe), 8'h0f);
      chk(8'(p3Oe), 8'h0f);
      chk(8'(p12Oe), 8'h01);
      chk(8'(p12Pu), 8'h00);
      chk(p1Oe, 8'ha5);
      chk(p1Pu, 8'h18);
      extEn = 8'h42;
      wr(PORT1_ADDR, 8'hc3);
      chk(p1Out, 8'hc3);
      chk(p1Oe, 8'ha5);
      repeat (4) @(posedge clock);
      rd_chk(PORT1_ADDR, 8'h99);
      rd_chk(PORT1_ADDR, 8'h99);
      chk(p1Out, 8'hc3);
      // Bit clear done as the processor does it: whole-byte read and write
      rd(PORT1_ADDR, r);
      wr(PORT1_ADDR, r & 8'h7f);
      chk(p1Out, 8'h19);
      wr(PORT0_ADDR, 8'hff);
      chk(8'(p0Out), 8'h0f);
      rd_chk(PORT0_ADDR, 8'h0f);
      wr(PORT3_ADDR, 8'h05);
      chk(8'(p3Out), 8'h05);
      wr(PORT12_ADDR, 8'hff);
      chk(8'(p12Out), 8'h01);
      wr(PORT13_ADDR, 8'hff);
      chk(8'(p13Out), 8'h01);
      rd_chk(PORT13_ADDR, 8'h01);
      wr(PORT2_ADDR, 8'h05);
      rd_chk(PORT2_ADDR, 8'h0a);
      // Second reset in mid-run
      @(posedge clock) #1 rst = 1'b1;
      repeat (2) @(posedge clock);
      #1 rst = 1'b0;
      chk(8'(p13Out), 8'h00);
      chk(p1Out, 8'h00);
      chk(p1Pu, 8'h00);
      rd_chk(PULL0_ADDR, 8'h00);
      rd_chk(DIR0_ADDR, 8'hff);
      end_sim();
   end
endmodule
`default_nettype wire
